// ==== verilog/ers_pkg.sv ====
package ers_pkg;

   // switch polarity: open reads one (enable), closed reads zero
   localparam logic SW_ENABLE     = 1'b1;
   localparam logic SW_DISABLE    = 1'b0;

   // code source selection values
   localparam logic SRC_PROG_RAM  = 1'b1;
   localparam logic SRC_PROG_ROM  = 1'b0;

   // program space and port geometry
   localparam int   PC_W          = 12;
   localparam int   PROG_BYTES    = 4096;
   localparam int   PORT_W        = 8;
   localparam int   NUM_PORTS     = 4;
   localparam logic [PC_W-1:0] PC_RESET = 12'h000;
   localparam logic [PORT_W-1:0] PORT_RESET = 8'hFF;

   // status and control register map (word offsets of this block)
   localparam logic [3:0] REG_CTRL   = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h1;
   localparam logic [3:0] REG_PORT0  = 4'h2;
   localparam int   CTRL_SUSP_BIT = 0;
   localparam logic [7:0] CTRL_RESET = 8'h00;

   // reset stretch length in clock cycles
   localparam logic [1:0] RST_STRETCH = 2'h3;

   // suspend cause record
   typedef enum logic [1:0] {
      ERS_SUSP_NONE = 2'b00,
      ERS_SUSP_POR  = 2'b01,
      ERS_SUSP_SW   = 2'b11
   } ers_susp_t;

   // run state of the emulated core
   typedef enum logic [1:0] {
      ERS_RESET = 2'b00,
      ERS_HALT  = 2'b01,
      ERS_RUN   = 2'b11,
      ERS_SUSP  = 2'b10
   } ers_state_t;

   // configuration switch bundle
   typedef struct packed {
      logic usb_reset_enable_switch;
      logic watchdog_reset_enable_switch;
      logic port_input_only_switch;
      logic suspend_after_poweron_switch;
      logic code_source_switch;
      logic run_after_reset_switch;
   } ers_sw_t;

   // program ram write request from the debug side
   typedef struct packed {
      logic            we;
      logic [PC_W-1:0] addr;
      logic [7:0]      data;
   } ers_pwr_t;

endpackage

// ==== verilog/ers_ctrl.sv ====
// Functional notes
// - usb bus reset counts only while its enable switch is set
// - watchdog expiry counts only while its enable switch is set
// - manual button acts exactly like power-on reset
// - every reset clears the core program counter to zero
// - every reset returns control registers to defaults
// - power-on or button reset enters suspend when switch enables it
// - after reset run from zero or halt at zero per switch
// - software writing one to suspend bit enters suspend
// - suspend stops core execution and its timer
// - bus activity, any reset or interrupt ends suspend
// - monitor run wakes suspend only if software entered it
// - monitor run never ends power-on suspend
// - program ram untouched by manual reset
// - power-up or manual reset loads ones into all port bits
// - code fetched from rom or program ram per source switch
// - program space limited to 4k for both sources
// - debug side may rewrite program ram bytes, retained until rewritten; writes land only while the source switch selects program ram
// - input-only switch keeps port bits from ever driving low
// - switches read open as one enable, closed as zero
`timescale 1ns/1ps
module ers_ctrl
   import ers_pkg::*;
(
   // clock and board power-on reset
   input  wire logic                  clk_in,
   input  wire logic                  rst_in,
   // asynchronous reset sources and switches
   input  wire logic                  manual_reset_button_in,
   input  wire logic                  usb_bus_reset_in,
   input  wire logic                  watchdog_expiry_in,
   input  wire ers_sw_t               switches_in,
   // wake sources
   input  wire logic                  usb_bus_active_in,
   input  wire logic                  interrupt_in,
   // debug monitor
   input  wire logic                  mon_run_in,
   input  wire logic                  mon_halt_in,
   input  wire ers_pwr_t              prog_wr_in,
   // core fetch and rom
   input  wire logic [PC_W-1:0]       fetch_addr_in,
   input  wire logic [7:0]            rom_data_in,
   output logic [7:0]                 fetch_data_out,
   output logic [PC_W-1:0]            rom_addr_out,
   // register port
   input  wire logic [3:0]            reg_addr_in,
   input  wire logic [7:0]            reg_wdata_in,
   input  wire logic                  reg_wr_in,
   input  wire logic                  reg_rd_in,
   output logic [7:0]                 reg_rdata_out,
   // core control
   output logic                       core_reset_out,
   output logic                       pc_clear_out,
   output logic                       core_run_out,
   output logic                       timer_run_out,
   output logic                       suspended_out,
   // port pin drive, open drain style
   output logic [NUM_PORTS*PORT_W-1:0] port_data_out,
   output logic [NUM_PORTS*PORT_W-1:0] port_oe_out
);

   // two-flop synchronisers for off-domain inputs
   logic [1:0] btn_s, usb_s, wdt_s, act_s, irq_s;
   logic [5:0] sw_m, sw_s;
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         btn_s <= 2'h0;
         usb_s <= 2'h0;
         wdt_s <= 2'h0;
         act_s <= 2'h0;
         irq_s <= 2'h0;
         sw_m  <= 6'h00;
         sw_s  <= 6'h00;
      end else begin
         btn_s <= {btn_s[0], manual_reset_button_in};
         usb_s <= {usb_s[0], usb_bus_reset_in};
         wdt_s <= {wdt_s[0], watchdog_expiry_in};
         act_s <= {act_s[0], usb_bus_active_in};
         irq_s <= {irq_s[0], interrupt_in};
         sw_m  <= switches_in;
         sw_s  <= sw_m;
      end
   end

   ers_sw_t sw;
   assign sw = ers_sw_t'(sw_s); // open reads as one

   // source gating; button is a power-on class source
   logic por_src, warm_src, any_src;
   assign por_src  = btn_s[1];
   assign warm_src = (usb_s[1] & (sw.usb_reset_enable_switch == SW_ENABLE))
      | (wdt_s[1] & (sw.watchdog_reset_enable_switch == SW_ENABLE));
   assign any_src  = por_src | warm_src;

   // merged reset, stretched so a short pulse still lasts cycles
   logic [1:0] rst_cnt_reg;
   logic       por_pend_reg;
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         rst_cnt_reg  <= RST_STRETCH;
         por_pend_reg <= 1'b1;
      end else if (any_src) begin
         rst_cnt_reg  <= RST_STRETCH;
         por_pend_reg <= por_pend_reg | por_src;
      end else if (rst_cnt_reg != 2'h0) begin
         rst_cnt_reg <= rst_cnt_reg - 2'h1;
      end else begin
         por_pend_reg <= 1'b0;
      end
   end

   logic int_rst;
   assign int_rst = any_src | (rst_cnt_reg != 2'h0);
   // release edge: last cycle of the held reset
   logic rst_release;
   assign rst_release = (rst_cnt_reg == 2'h1) & ~any_src;

   // software suspend request
   logic sw_susp_wr;
   assign sw_susp_wr = reg_wr_in & (reg_addr_in == REG_CTRL)
      & reg_wdata_in[CTRL_SUSP_BIT];

   // control register and port output latches
   logic [7:0] ctrl_reg;
   logic [PORT_W-1:0] port_reg [NUM_PORTS];
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         ctrl_reg <= CTRL_RESET;
         for (int i = 0; i < NUM_PORTS; i++) port_reg[i] <= PORT_RESET;
      end else if (int_rst) begin
         ctrl_reg <= CTRL_RESET;
         for (int i = 0; i < NUM_PORTS; i++)
            port_reg[i] <= PORT_RESET;
      end else if (reg_wr_in) begin
         if (reg_addr_in == REG_CTRL) ctrl_reg <= reg_wdata_in;
         for (int i = 0; i < NUM_PORTS; i++)
            if (reg_addr_in == REG_PORT0 + 4'(i))
               port_reg[i] <= reg_wdata_in;
      end
   end

   // run state and suspend cause
   ers_state_t state_reg;
   ers_susp_t  cause_reg;
   logic       wake;
   assign wake = act_s[1] | irq_s[1];

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         state_reg <= ERS_RESET;
         cause_reg <= ERS_SUSP_NONE;
      end else if (int_rst) begin
         state_reg <= ERS_RESET; // a reset also ends suspend
         cause_reg <= ERS_SUSP_NONE;
      end else begin
         unique case (state_reg)
            ERS_RESET: begin
               if (rst_release | (rst_cnt_reg == 2'h0)) begin
                  if (por_pend_reg &
                      sw.suspend_after_poweron_switch == SW_ENABLE) begin
                     state_reg <= ERS_SUSP;
                     cause_reg <= ERS_SUSP_POR;
                  end else if (sw.run_after_reset_switch == SW_ENABLE)
                     state_reg <= ERS_RUN;
                  else
                     state_reg <= ERS_HALT;
               end
            end
            ERS_HALT: begin
               if (mon_run_in) state_reg <= ERS_RUN;
            end
            ERS_RUN: begin
               if (sw_susp_wr) begin
                  state_reg <= ERS_SUSP;
                  cause_reg <= ERS_SUSP_SW;
               end else if (mon_halt_in) state_reg <= ERS_HALT;
            end
            ERS_SUSP: begin
               // run ends only a software suspend
               if (wake | (mon_run_in & cause_reg == ERS_SUSP_SW)) begin
                  state_reg <= ERS_RUN;
                  cause_reg <= ERS_SUSP_NONE;
               end
            end
         endcase
      end
   end

   // core control outputs
   assign core_reset_out = int_rst;
   assign pc_clear_out   = int_rst | (state_reg == ERS_RESET);
   assign core_run_out   = (state_reg == ERS_RUN);
   assign timer_run_out  = (state_reg == ERS_RUN);
   assign suspended_out  = (state_reg == ERS_SUSP);

   // program ram: no reset so contents survive the button
   logic [7:0] prog_ram [PROG_BYTES];
   always_ff @(posedge clk_in) begin
      if (prog_wr_in.we & (sw.code_source_switch == SRC_PROG_RAM))
         prog_ram[prog_wr_in.addr] <= prog_wr_in.data;
   end

   // fetch mux, address width caps space at 4k
   assign rom_addr_out = fetch_addr_in;
   logic [7:0] ram_q;
   always_ff @(posedge clk_in) begin
      ram_q <= prog_ram[fetch_addr_in];
   end
   logic [7:0] rom_q;
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) rom_q <= 8'h00;
      else rom_q <= rom_data_in;
   end
   assign fetch_data_out = (sw.code_source_switch == SRC_PROG_RAM)
      ? ram_q : rom_q;

   // pseudo-bidirectional pins: drive only a zero, never a one
   always_comb begin
      for (int i = 0; i < NUM_PORTS; i++) begin
         port_data_out[i*PORT_W +: PORT_W] = {PORT_W{1'b0}};
         port_oe_out[i*PORT_W +: PORT_W] =
            (sw.port_input_only_switch == SW_ENABLE)
            ? {PORT_W{1'b0}} : ~port_reg[i];
      end
   end

   // register read, data one cycle after the strobe
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) reg_rdata_out <= 8'h00;
      else if (reg_rd_in) begin
         if (reg_addr_in == REG_CTRL) reg_rdata_out <= ctrl_reg;
         else if (reg_addr_in == REG_STATUS)
            reg_rdata_out <= {4'h0, cause_reg, state_reg};
         else if (reg_addr_in >= REG_PORT0 &&
                  reg_addr_in < REG_PORT0 + 4'(NUM_PORTS))
            reg_rdata_out <= port_reg[2'(reg_addr_in - REG_PORT0)];
         else reg_rdata_out <= 8'h00;
      end
   end

   // checks
   a_run_susp_excl: assert property (@(posedge clk_in) disable iff (rst_in)
      suspended_out |-> !core_run_out && !timer_run_out)
      else $error("core runs while suspended");
   a_por_susp_hold: assert property (@(posedge clk_in) disable iff (rst_in)
      (suspended_out && cause_reg == ERS_SUSP_POR && !wake && !int_rst)
      |=> suspended_out)
      else $error("power-on suspend left by run");
   a_sw_susp_wake: assert property (@(posedge clk_in) disable iff (rst_in)
      (suspended_out && cause_reg == ERS_SUSP_SW && mon_run_in && !int_rst)
      |=> core_run_out)
      else $error("run did not wake software suspend");
   a_susp_entry: assert property (@(posedge clk_in) disable iff (rst_in)
      (core_run_out && sw_susp_wr && !int_rst && !mon_halt_in)
      |=> suspended_out && cause_reg == ERS_SUSP_SW)
      else $error("software suspend not entered");
   a_wake_exit: assert property (@(posedge clk_in) disable iff (rst_in)
      (suspended_out && wake && !int_rst) |=> core_run_out)
      else $error("wake did not end suspend");
   a_usb_gate: assert property (@(posedge clk_in) disable iff (rst_in)
      (usb_s[1] && sw.usb_reset_enable_switch == SW_DISABLE && !por_src
       && !wdt_s[1] && rst_cnt_reg == 2'h0) |-> !int_rst)
      else $error("disabled bus reset took effect");
   a_rst_held: assert property (@(posedge clk_in) disable iff (rst_in)
      $rose(any_src) |-> int_rst [*3])
      else $error("reset not held");
   a_port_ones: assert property (@(posedge clk_in) disable iff (rst_in)
      int_rst |=> port_reg[0] == PORT_RESET && ctrl_reg == CTRL_RESET)
      else $error("port not set after reset");
   a_input_only: assert property (@(posedge clk_in) disable iff (rst_in)
      sw.port_input_only_switch == SW_ENABLE |-> port_oe_out == '0)
      else $error("pin driven in input-only mode");

   // helpers for the exit of the reset state
   logic rst_leave;
   logic por_susp_go;
   assign rst_leave   = (state_reg == ERS_RESET) & ~int_rst;
   assign por_susp_go = por_pend_reg
      & (sw.suspend_after_poweron_switch == SW_ENABLE);

   // stretch tail: three held cycles after the last source drops
   sequence s_src_drop;
      $fell(any_src);
   endsequence
   sequence s_held_three;
      int_rst ##1 int_rst ##1 int_rst;
   endsequence

   a_rst_tail: assert property (@(posedge clk_in) disable iff (rst_in)
      s_src_drop |-> s_held_three)
      else $error("reset tail too short");

   // every reset pulls the program counter back to zero
   a_pc_clear_rst: assert property (@(posedge clk_in) disable iff (rst_in)
      int_rst |-> pc_clear_out && core_reset_out)
      else $error("pc not cleared during reset");

   // state machine returns to its default on any reset
   a_state_default: assert property (@(posedge clk_in) disable iff (rst_in)
      int_rst |=> state_reg == ERS_RESET && cause_reg == ERS_SUSP_NONE)
      else $error("state not defaulted by reset");

   // watchdog gating mirrors the bus reset gate
   a_wdt_gate: assert property (@(posedge clk_in) disable iff (rst_in)
      (wdt_s[1] && sw.watchdog_reset_enable_switch == SW_DISABLE
       && !por_src && !usb_s[1] && rst_cnt_reg == 2'h0) |-> !int_rst)
      else $error("disabled watchdog took effect");

   // power-on class reset with the switch set ends in suspend
   a_por_susp: assert property (@(posedge clk_in) disable iff (rst_in)
      (rst_leave && por_susp_go)
      |=> suspended_out && cause_reg == ERS_SUSP_POR)
      else $error("power-on suspend not entered");

   // warm resets never lead into suspend
   a_warm_no_susp: assert property (@(posedge clk_in) disable iff (rst_in)
      (rst_leave && !por_pend_reg) |=> !suspended_out)
      else $error("warm reset entered suspend");

   // run switch picks run or halt when the reset state is left
   a_run_after: assert property (@(posedge clk_in) disable iff (rst_in)
      (rst_leave && !por_susp_go
       && sw.run_after_reset_switch == SW_ENABLE) |=> core_run_out)
      else $error("core not started after reset");
   a_halt_after: assert property (@(posedge clk_in) disable iff (rst_in)
      (rst_leave && !por_susp_go
       && sw.run_after_reset_switch == SW_DISABLE)
      |=> state_reg == ERS_HALT)
      else $error("core not halted after reset");

   // monitor break and run move between halt and run
   a_halt_entry: assert property (@(posedge clk_in) disable iff (rst_in)
      (core_run_out && mon_halt_in && !sw_susp_wr && !int_rst)
      |=> state_reg == ERS_HALT)
      else $error("break did not halt core");
   a_halt_run: assert property (@(posedge clk_in) disable iff (rst_in)
      (state_reg == ERS_HALT && mon_run_in && !int_rst)
      |=> core_run_out)
      else $error("run did not start halted core");

   // cause record is gone once suspend ends
   a_cause_clear: assert property (@(posedge clk_in) disable iff (rst_in)
      $fell(suspended_out) |-> cause_reg == ERS_SUSP_NONE)
      else $error("suspend cause kept after exit");

   // timer and core always stop and start together
   a_timer_follow: assert property (@(posedge clk_in) disable iff (rst_in)
      timer_run_out == core_run_out)
      else $error("timer and core disagree");

   // pins are only ever pulled low, never driven high
   a_port_no_high: assert property (@(posedge clk_in) disable iff (rst_in)
      port_data_out == '0)
      else $error("pin driven high");

   // rom path: fetched byte is the rom byte of the cycle before
   a_rom_fetch: assert property (@(posedge clk_in) disable iff (rst_in)
      sw.code_source_switch == SRC_PROG_ROM
      |=> sw.code_source_switch != SRC_PROG_ROM
          || fetch_data_out == $past(rom_data_in))
      else $error("rom byte not fetched");

   // fetch address passes to the rom unwidened, capping space
   a_rom_addr: assert property (@(posedge clk_in) disable iff (rst_in)
      rom_addr_out == fetch_addr_in)
      else $error("rom address altered");

endmodule // ers_ctrl

// ==== dv/ers_rom_model.sv ====
`timescale 1ns/1ps
// external program rom as the core fetch path sees it
module ers_rom_model
   import ers_pkg::*;
(
   // fetch address from the block
   input  wire logic [PC_W-1:0] rom_addr_in,
   // byte at that address
   output logic [7:0]           rom_data_out
);
   // address-derived pattern: each location distinct from program ram
   assign rom_data_out = rom_addr_in[7:0] ^ 8'hC3;
endmodule // ers_rom_model

// ==== dv/ers_ctrl_tb.sv ====
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
   $display("BAD %s exp %h got %h", n, e, g); end end
module ers_ctrl_tb;
   import ers_pkg::*;
   logic clk_in, rst_in, mon_run_in, mon_halt_in, reg_wr_in, reg_rd_in;
   logic [4:0]  src;
   ers_sw_t     sw;
   ers_pwr_t    pw;
   logic [11:0] fa, ra;
   logic [7:0]  rd_d, fd, rom_d, rv, wd;
   logic [3:0]  ad;
   logic        crst, pclr, crun, trun, susp;
   logic [31:0] pdat, poe;
   int          n_fail = 0, tests_run = 0, cyc = 0;

   ers_rom_model rom (.rom_addr_in(ra), .rom_data_out(rom_d));
   ers_ctrl dut (.clk_in(clk_in), .rst_in(rst_in),
      .manual_reset_button_in(src[0]), .usb_bus_reset_in(src[1]),
      .watchdog_expiry_in(src[2]), .switches_in(sw),
      .usb_bus_active_in(src[3]), .interrupt_in(src[4]),
      .mon_run_in(mon_run_in), .mon_halt_in(mon_halt_in), .prog_wr_in(pw),
      .fetch_addr_in(fa), .rom_data_in(rom_d), .fetch_data_out(fd),
      .rom_addr_out(ra), .reg_addr_in(ad), .reg_wdata_in(wd),
      .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(rd_d),
      .core_reset_out(crst), .pc_clear_out(pclr), .core_run_out(crun),
      .timer_run_out(trun), .suspended_out(susp), .port_data_out(pdat),
      .port_oe_out(poe));

   // free-running board clock, 8 ns
   initial begin
      clk_in = 1'b0;
      forever #4 clk_in = ~clk_in;
   end

   task automatic complete_run;
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // hang guard, run needs well under a thousand cycles
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 5000) begin
         n_fail++;
         complete_run;
      end
   end

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_in);
      reg_wr_in <= 1'b1; ad <= a; wd <= d;
      @(posedge clk_in);
      reg_wr_in <= 1'b0;
   endtask

   // read data appear in the cycle after the strobe and hold until the next read
   task automatic rdc(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk_in);
      reg_rd_in <= 1'b1; ad <= a;
      @(posedge clk_in);
      reg_rd_in <= 1'b0;
      #1 rv = rd_d;
      `CHK("reg read", e, rv)
   endtask

   // hold a source long enough to pass the two sync flops
   task automatic fire(input logic [4:0] m, input logic er);
      @(posedge clk_in);
      src <= m;
      repeat (4) @(posedge clk_in);
      #1 `CHK("core_reset", er, crst)
      `CHK("pc_clear", er, pclr)
      src <= 5'h00;
      repeat (10) @(posedge clk_in);
   endtask

   task automatic mrun;
      @(posedge clk_in);
      mon_run_in <= 1'b1;
      @(posedge clk_in);
      mon_run_in <= 1'b0;
      repeat (3) @(posedge clk_in);
   endtask

   // monitor break pulse, one cycle
   task automatic mhalt;
      @(posedge clk_in);
      mon_halt_in <= 1'b1;
      @(posedge clk_in);
      mon_halt_in <= 1'b0;
      repeat (3) @(posedge clk_in);
   endtask

   task automatic fet(input logic [11:0] a, input logic [7:0] e);
      @(posedge clk_in);
      fa <= a;
      repeat (2) @(posedge clk_in);
      #1 `CHK("fetch", e, fd)
   endtask

   // switches change slowly; allow the sync flops to settle
   task automatic swset(input logic [5:0] v);
      @(posedge clk_in);
      sw <= v;
      repeat (4) @(posedge clk_in);
   endtask

   initial begin
      rst_in = 1'b1; src = 5'h00; sw = 6'b000001; pw = '0;
      fa = 12'h000; ad = 4'h0; wd = 8'h00;
      mon_run_in = 1'b0; reg_wr_in = 1'b0; reg_rd_in = 1'b0;
      mon_halt_in = 1'b0;
      repeat (4) @(posedge clk_in);
      rst_in <= 1'b0;
      repeat (8) @(posedge clk_in);
      rdc(REG_STATUS, 8'h03);
      `CHK("core_run", 1'b1, crun)
      mhalt;
      rdc(REG_STATUS, 8'h01);
      mrun;
      rdc(REG_STATUS, 8'h03);
      `CHK("port data", 32'h0, pdat)
      rdc(REG_PORT0, 8'hFF);
      rdc(REG_CTRL, CTRL_RESET);
      rdc(4'hF, 8'h00);
      wr(REG_PORT0, 8'h00);
      #1 `CHK("port oe", 8'hFF, poe[7:0])
      swset(6'b001001);
      #1 `CHK("port oe", 8'h00, poe[7:0])
      swset(6'b000001);
      wr(REG_CTRL, 8'h01);
      rdc(REG_STATUS, 8'h0E);
      `CHK("core_run", 1'b0, crun)
      `CHK("timer_run", 1'b0, trun)
      `CHK("suspended", 1'b1, susp)
      mrun;
      rdc(REG_STATUS, 8'h03);
      wr(REG_CTRL, 8'h01);
      fire(5'h08, 1'b0);
      rdc(REG_STATUS, 8'h03);
      wr(REG_CTRL, 8'h01);
      fire(5'h10, 1'b0);
      rdc(REG_STATUS, 8'h03);
      fire(5'h02, 1'b0);
      rdc(REG_PORT0, 8'h00);
      swset(6'b100101);
      fire(5'h02, 1'b1);
      rdc(REG_STATUS, 8'h03);
      rdc(REG_PORT0, 8'hFF);
      wr(REG_PORT0, 8'h00);
      fire(5'h04, 1'b0);
      swset(6'b110111);
      fire(5'h04, 1'b1);
      rdc(REG_PORT0, 8'hFF);
      @(posedge clk_in);
      pw <= '{1'b1, 12'hFFF, 8'h5A};
      @(posedge clk_in);
      pw <= '0;
      fet(12'hFFF, 8'h5A);
      wr(REG_PORT0, 8'h00);
      fire(5'h01, 1'b1);
      rdc(REG_STATUS, 8'h06);
      rdc(REG_PORT0, 8'hFF);
      mrun;
      rdc(REG_STATUS, 8'h06);
      fet(12'hFFF, 8'h5A);
      fire(5'h10, 1'b0);
      rdc(REG_STATUS, 8'h03);
      swset(6'b110000);
      fire(5'h01, 1'b1);
      rdc(REG_STATUS, 8'h01);
      `CHK("core_run", 1'b0, crun)
      mrun;
      rdc(REG_STATUS, 8'h03);
      wr(REG_CTRL, 8'h01);
      fire(5'h02, 1'b1);
      rdc(REG_STATUS, 8'h01);
      fet(12'h034, 8'h34 ^ 8'hC3);
      complete_run;
   end
endmodule // ers_ctrl_tb
